// [bench/host_model.sv]
// host-side pad model: resolves each pad from device, host and pull-up
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  input  wire logic [9:0] host_lvl,
  input  wire logic [9:0] pin_out,
  input  wire logic [9:0] pin_oe,
  input  wire logic [9:0] pin_pull_en,
  output logic      [9:0] host_en,
  output logic      [9:0] pin_in
);
  logic [9:0] wobble = 10'h155;
  // a floating pad without pull-up must not look like a stable level
  always_ff @(posedge clk) wobble <= ~wobble;
  // the host keeps the select strap and every other pad it owns driven
  assign host_en = 10'h3ff;
  // device drive wins, then the host, then the pull-up
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : host_en[i] ? host_lvl[i] : pin_pull_en[i] | wobble[i];
    end
  end
endmodule
`default_nettype wire

// [bench/pin_mux_assertions.sv]
// concurrent checks on the pin mux and boot strap ports
`timescale 1ns/100ps
`default_nettype none
module pin_mux_assertions (
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire logic [9:0]              pin_in,
  input wire logic [9:0]              pin_out,
  input wire logic [9:0]              pin_oe,
  input wire logic [9:0]              pin_pull_en,
  input wire logic                    reset_drive_en,
  input wire logic                    reset_drive_assert,
  input wire logic                    reset_pin_n_out,
  input wire logic                    reset_pin_n_oe,
  input wire logic [19:0]             sel_rdata,
  input wire logic [3:0]              rio_op,
  input wire logic [15:0]             rio_wdata,
  input wire logic [15:0]             rio_rdata,
  input wire logic [1:0]              trig_mode,
  input wire logic                    irq_pending,
  input wire logic [2:0]              irq_level,
  input wire logic                    wake_req,
  input wire logic                    command_complete_flag,
  input wire pin_mux_pkg::periph_in_t periph_in,
  input wire pin_mux_pkg::strap_t     straps
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // the sync wait and the capture edge after release are excused, later edges are not
  property p_strap_hold; $past(nrst, 4) |-> $stable(straps); endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("straps moved");
  property p_rst_drive;
    reset_pin_n_oe == (reset_drive_en && reset_drive_assert) && !reset_pin_n_out;
  endproperty
  a_rst_drive: assert property (p_rst_drive) else $error("reset pin drive");
  property p_wake; wake_req == irq_pending && irq_level == 3'h7; endproperty
  a_wake: assert property (p_wake) else $error("wake level");
  property p_hit_gate; $rose(irq_pending) |-> $past(sel_rdata[9:8]) == 2'h1; endproperty
  a_hit_gate: assert property (p_hit_gate) else $error("hit while deselected");
  // two sync stages, then the detector: the answer lands a few edges later
  property p_rise_walk;
    sel_rdata[9:8] == 2'h1 && trig_mode == 2'h0 && $rose(pin_in[4]) |-> ##[2:4] irq_pending;
  endproperty
  a_rise_walk: assert property (p_rise_walk) else $error("rise missed");
  property p_rio_set;
    rio_op == 4'h2 |=> (rio_rdata[15:10] & $past(rio_wdata[15:10])) == $past(rio_wdata[15:10]);
  endproperty
  a_rio_set: assert property (p_rio_set) else $error("set op");
  property p_rio_tog;
    rio_op == 4'h8 |=> rio_rdata[15:10] == ($past(rio_rdata[15:10]) ^ $past(rio_wdata[15:10]));
  endproperty
  a_rio_tog: assert property (p_rio_tog) else $error("toggle op");
  property p_int_out;
    sel_rdata[11:10] == 2'h2 |-> pin_out[5] == command_complete_flag && pin_oe[5];
  endproperty
  a_int_out: assert property (p_int_out) else $error("slave irq pin");
  property p_pull9; pin_pull_en[9]; endproperty
  a_pull9: assert property (p_pull9) else $error("debug pull-up");
  property p_idle; sel_rdata[3:2] != 2'h0 |-> periph_in.slave_sda; endproperty
  a_idle: assert property (p_idle) else $error("deselected input not idle");
  c_hit: cover property (sel_rdata[9:8] == 2'h1 && $rose(irq_pending));
  c_tog: cover property (rio_op == 4'h8);
  c_rst: cover property (reset_pin_n_oe);
endmodule
bind pin_function_mux_and_boot_strap pin_mux_assertions u_pin_mux_assertions (
  .clk, .nrst, .pin_in, .pin_out, .pin_oe, .pin_pull_en, .reset_drive_en,
  .reset_drive_assert, .reset_pin_n_out, .reset_pin_n_oe, .sel_rdata, .rio_op,
  .rio_wdata, .rio_rdata, .trig_mode, .irq_pending, .irq_level, .wake_req,
  .command_complete_flag, .periph_in, .straps
);
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the pin mux, rapid port, interrupt input and straps
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic nrst, sel_we, pull_we, rio_dir_we, reset_drive_en, reset_drive_assert, irq_clear;
  logic command_complete_flag, reset_pin_n_in, reset_pin_n_out, reset_pin_n_oe, rst_pad;
  logic irq_pending, wake_req, analog_pair_en, act;
  logic [9:0] pin_in, pin_out, pin_oe, pin_pull_en, pull_wdata, host_lvl;
  logic [19:0] sel_wdata, sel_rdata;
  logic [15:0] rio_wdata, rio_dir_wdata, rio_rdata, m;
  logic [3:0] rio_op, host_irq_src, host_irq_en;
  logic [1:0] trig_mode;
  logic [2:0] irq_level;
  logic [31:0] lfsr = 32'h02c7;
  logic [3:0] ops [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
  int err_count = 0;
  int n_checks = 0;
  pin_mux_pkg::periph_out_t periph_out;
  pin_mux_pkg::periph_in_t periph_in;
  pin_mux_pkg::strap_t straps;
  always #2 clk = ~clk;
  // open-drain reset pad: device pulls low, else the outside level
  assign reset_pin_n_in = reset_pin_n_oe ? reset_pin_n_out : rst_pad;
  pin_function_mux_and_boot_strap u_pin_function_mux_and_boot_strap (
    .clk, .nrst, .pin_in, .pin_out, .pin_oe, .pin_pull_en, .reset_pin_n_in,
    .reset_pin_n_out, .reset_pin_n_oe, .sel_wdata, .sel_we, .sel_rdata, .pull_wdata,
    .pull_we, .reset_drive_en, .reset_drive_assert, .rio_op, .rio_wdata,
    .rio_dir_wdata, .rio_dir_we, .rio_rdata, .host_irq_src, .host_irq_en, .trig_mode,
    .irq_clear, .irq_pending, .irq_level, .wake_req, .command_complete_flag,
    .periph_out, .periph_in, .analog_pair_en, .straps
  );
  host_model u_host_model (
    .clk, .host_lvl, .pin_out, .pin_oe, .pin_pull_en, .host_en(), .pin_in
  );
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    err_count++;
    give_verdict();
  end
  initial begin
    {nrst, sel_we, pull_we, rio_dir_we, reset_drive_en, reset_drive_assert} = '0;
    {irq_clear, command_complete_flag, host_irq_src, host_irq_en, trig_mode} = '0;
    {sel_wdata, pull_wdata, rio_op, rio_wdata, rio_dir_wdata} = '0;
    periph_out = '0;
    // two start-ups with opposite strap levels, then pad activity
    for (int k = 0; k < 2; k++) begin
      nrst = 1'b0;
      host_lvl = k ? 10'h208 : 10'h001;
      rst_pad = (k == 0);
      tick(12);
      nrst = 1'b1;
      tick(3);
      check("straps", straps, {~host_lvl[3], rst_pad, ~host_lvl[9]});
      check("sel reset", sel_rdata, 20'h0);
      check("oe reset", pin_oe, 10'h0);
      check("pull reset", pin_pull_en, 10'h200);
      check("rio reset", rio_rdata[15:10], 6'h0);
      check("slave clk", periph_in.slave_scl, host_lvl[0]);
      host_lvl = ~host_lvl;
      tick(4);
      check("straps held", straps, {host_lvl[3], rst_pad, host_lvl[9]});
      check("pin4 unselected", irq_pending, 1'b0);
    end
    // rapid port: all ops and a refused two-hot op with random operands
    m = '0;
    rio_dir_wdata = 16'hffff;
    rio_dir_we = 1'b1;
    tick(1);
    rio_dir_we = 1'b0;
    for (int i = 0; i < 25; i++) begin
      lfsr = next_rand(lfsr);
      rio_op = ops[i % 5];
      rio_wdata = lfsr[15:0];
      tick(1);
      rio_op = 4'h0;
      case (ops[i % 5])
        4'h1: m = rio_wdata;
        4'h2: m = m | rio_wdata;
        4'h4: m = m & ~rio_wdata;
        4'h8: m = m ^ rio_wdata;
        default: m = m;
      endcase
      tick(3);
      check("rio stored", rio_rdata[15:10], m[15:10]);
      check("rio pads", rio_rdata[8:2], m[8:2]);
    end
    // host interrupt outputs on the upper rapid pins
    host_irq_src = lfsr[3:0];
    host_irq_en = 4'hf;
    tick(1);
    check("irq pins", {pin_oe[9:6], pin_out[9:6]}, {4'hf, host_irq_src});
    host_irq_en = 4'h0;
    // reassign pins 0..8 (pin 9 keeps its first function), spi side and analog pair selected
    host_lvl[1:0] = 2'b01;
    periph_out.spi_data_out = 1'b1;
    periph_out.spi_data_out_oe = 1'b1;
    periph_out.delay_block_out_b = 1'b1;
    sel_wdata = 20'h1596a;
    sel_we = 1'b1;
    tick(1);
    sel_we = 1'b0;
    tick(3);
    check("sel write", sel_rdata, 20'h1596a);
    check("slave sda idle", periph_in.slave_sda, 1'b1);
    check("spi clock", periph_in.spi_clock, 1'b1);
    check("master sda", periph_in.master_sda, host_lvl[3]);
    check("spi out", {pin_oe[2], pin_out[2]}, 2'b11);
    check("spi in", periph_in.spi_data_in, host_lvl[1]);
    check("delay b", {pin_oe[8], pin_out[8]}, 2'b11);
    check("analog pair", analog_pair_en, 1'b1);
    for (int i = 0; i < 4; i++) begin
      command_complete_flag = i[0];
      host_irq_src = ~host_irq_src;
      tick(1);
      check("slave irq pin", pin_out[5], command_complete_flag);
    end
    // interrupt input in every trigger mode
    for (int t = 0; t < 4; t++) begin
      act = (t == 0 || t == 2);
      trig_mode = t[1:0];
      host_lvl[4] = ~act;
      tick(4);
      irq_clear = 1'b1;
      tick(1);
      irq_clear = 1'b0;
      tick(2);
      check("irq idle", irq_pending, 1'b0);
      host_lvl[4] = act;
      tick(2);
      check("irq early", irq_pending, 1'b0);
      tick(2);
      check("irq hit", irq_pending, 1'b1);
      check("wake", {wake_req, irq_level}, 4'hf);
    end
    // reset pad drive and pull-up register
    reset_drive_en = 1'b1;
    tick(1);
    check("reset pad idle", reset_pin_n_oe, 1'b0);
    reset_drive_assert = 1'b1;
    tick(1);
    check("reset pad drive", {reset_pin_n_oe, reset_pin_n_in}, 2'b10);
    reset_drive_assert = 1'b0;
    pull_wdata = lfsr[9:0];
    pull_we = 1'b1;
    tick(1);
    pull_we = 1'b0;
    check("pulls", pin_pull_en, {1'b1, pull_wdata[8:0]});
    give_verdict();
  end
endmodule
`default_nettype wire

// [hdl/pin_function_mux_and_boot_strap.sv]
// pin-function multiplexer, rapid io port, interrupt input and boot straps
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - after reset every pin selects its first listed function
// - firmware reassigns each pin through its own select field
// - pins 0..3 choose rapid bit, slave serial, master serial or spi functions
// - pins 4..8 choose rapid bit, interrupt, delay, analog or timer functions
// - spi select level at start-up picks spi (low) or i2c (high)
// - reset pin is input at start-up, firmware may enable open-drain drive
// - reset pin high at power-up boots application, low boots rom
// - debug strap high boots normally, low enters single-wire debug mode
// - rapid port is 16 bits with write, set, clear, toggle; 10 reach pins
// - rapid pins reset as inputs with pull-ups off, except pin 9, which is always pulled up
// - rapid bits 9..6 can carry interrupt outputs to the host
// - rapid bit 9 shares debug pin; bits 1,0 sit on slave serial at reset
// - interrupt input triggers on rise, fall, high or low; wakes at level 7
// - slave-port interrupt output follows only the command-complete flag
// - analog pins pair as differential inputs at the accelerometer rate
module pin_function_mux_and_boot_strap #(
  parameter int unsigned RIO_WIDTH = pin_mux_pkg::RIO_WIDTH,
  parameter int unsigned PIN_COUNT = pin_mux_pkg::PIN_COUNT
) (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  // pads
  input  wire logic [PIN_COUNT-1:0]    pin_in,
  output logic [PIN_COUNT-1:0]         pin_out,
  output logic [PIN_COUNT-1:0]         pin_oe,
  output logic [PIN_COUNT-1:0]         pin_pull_en,
  input  wire logic                    reset_pin_n_in,
  output logic                         reset_pin_n_out,
  output logic                         reset_pin_n_oe,
  // mux control
  input  wire logic [2*PIN_COUNT-1:0]  sel_wdata,
  input  wire logic                    sel_we,
  output logic [2*PIN_COUNT-1:0]       sel_rdata,
  input  wire logic [PIN_COUNT-1:0]    pull_wdata,
  input  wire logic                    pull_we,
  input  wire logic                    reset_drive_en,
  input  wire logic                    reset_drive_assert,
  // rapid port
  input  wire logic [3:0]              rio_op,
  input  wire logic [RIO_WIDTH-1:0]    rio_wdata,
  input  wire logic [RIO_WIDTH-1:0]    rio_dir_wdata,
  input  wire logic                    rio_dir_we,
  output logic [RIO_WIDTH-1:0]         rio_rdata,
  input  wire logic [3:0]              host_irq_src,
  input  wire logic [3:0]              host_irq_en,
  // interrupt input
  input  wire logic [1:0]              trig_mode,
  input  wire logic                    irq_clear,
  output logic                         irq_pending,
  output logic [2:0]                   irq_level,
  output logic                         wake_req,
  // slave-port interrupt and peripherals
  input  wire logic                    command_complete_flag,
  input  wire pin_mux_pkg::periph_out_t periph_out,
  output pin_mux_pkg::periph_in_t      periph_in,
  output logic                         analog_pair_en,
  // straps
  output pin_mux_pkg::strap_t          straps
);
  logic [2*PIN_COUNT-1:0] sel;
  logic [PIN_COUNT-1:0]   pull;
  logic [RIO_WIDTH-1:0]   rio_out;
  logic [RIO_WIDTH-1:0]   rio_dir;
  logic [PIN_COUNT-1:0]   sync1;
  logic [PIN_COUNT-1:0]   sync2;
  logic                   rst_sync1;
  logic                   rst_sync2;
  logic                   irq_prev;
  logic                   strap_done;
  logic [1:0]             strap_age;
  logic                   trig_hit;
  logic [RIO_WIDTH-1:0]   next_rio_out;
  logic [1:0]             s [PIN_COUNT];

  // mux select storage, all zero gives the first function
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel <= '0;
    end else if (sel_we) begin
      sel <= sel_wdata;
    end
  end
  assign sel_rdata = sel;

  // pull-up enables, off after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pull <= pin_mux_pkg::PULL_RESET;
    end else if (pull_we) begin
      pull <= pull_wdata;
    end
  end

  // rapid port single-cycle operations
  always_comb begin
    next_rio_out = rio_out;
    case (rio_op)
      pin_mux_pkg::RIO_WRITE:  next_rio_out = rio_wdata;
      pin_mux_pkg::RIO_SET:    next_rio_out = rio_out | rio_wdata;
      pin_mux_pkg::RIO_CLEAR:  next_rio_out = rio_out & ~rio_wdata;
      pin_mux_pkg::RIO_TOGGLE: next_rio_out = rio_out ^ rio_wdata;
      default:                 next_rio_out = rio_out;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rio_out <= pin_mux_pkg::RIO_OUT_RESET;
    end else begin
      rio_out <= next_rio_out;
    end
  end

  // direction: all inputs after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rio_dir <= pin_mux_pkg::RIO_DIR_RESET;
    end else if (rio_dir_we) begin
      rio_dir <= rio_dir_wdata;
    end
  end

  // pad synchronisers; stage one feeds only stage two
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1     <= '0;
      sync2     <= '0;
      rst_sync1 <= 1'b1;
      rst_sync2 <= 1'b1;
    end else begin
      sync1     <= pin_in;
      sync2     <= sync1;
      rst_sync1 <= reset_pin_n_in;
      rst_sync2 <= rst_sync1;
    end
  end

  // upper port bits have no pad, so reads return stored output there
  always_comb begin
    rio_rdata = rio_out;
    rio_rdata[PIN_COUNT-1:0] = sync2;
  end

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sel
      assign s[gi] = sel[2*gi +: 2];
    end
  endgenerate

  // pad drive per pin; function 1 of pins 0,1 is slave serial, driven by its own block
  always_comb begin
    pin_out = '0;
    pin_oe  = '0;
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (s[i] == pin_mux_pkg::FUNC_1 && i != 0 && i != 1 && i != 9) begin
        pin_out[i] = rio_out[i];
        pin_oe[i]  = rio_dir[i];
      end
    end
    // pins 0,1: rapid bit as second function
    for (int i = 0; i < 2; i++) begin
      if (s[i] == pin_mux_pkg::FUNC_2) begin
        pin_out[i] = rio_out[i];
        pin_oe[i]  = rio_dir[i];
      end
    end
    // spi data out on pin 2, master serial open-drain on pins 2,3
    if (s[2] == pin_mux_pkg::FUNC_2) begin
      pin_out[2] = 1'b0;
      pin_oe[2]  = periph_out.master_scl_oe;
    end else if (s[2] == pin_mux_pkg::FUNC_3) begin
      pin_out[2] = periph_out.spi_data_out;
      pin_oe[2]  = periph_out.spi_data_out_oe;
    end
    if (s[3] == pin_mux_pkg::FUNC_2) begin
      pin_out[3] = 1'b0;
      pin_oe[3]  = periph_out.master_sda_oe;
    end
    // pin 5: delay output or slave-port interrupt
    if (s[5] == pin_mux_pkg::FUNC_2) begin
      pin_out[5] = periph_out.delay_block_out_a;
      pin_oe[5]  = 1'b1;
    end else if (s[5] == pin_mux_pkg::FUNC_3) begin
      pin_out[5] = command_complete_flag;
      pin_oe[5]  = 1'b1;
    end
    // pins 6,7: timers on function 3, analog leaves pad undriven
    for (int i = 0; i < 2; i++) begin
      if (s[6+i] == pin_mux_pkg::FUNC_3) begin
        pin_out[6+i] = periph_out.timer_out[i];
        pin_oe[6+i]  = periph_out.timer_oe[i];
      end else if (s[6+i] == pin_mux_pkg::FUNC_2) begin
        pin_oe[6+i]  = 1'b0;
      end
    end
    // host interrupt outputs on bits 6..9 override rapid data
    for (int i = 0; i < 4; i++) begin
      if (s[6+i] == pin_mux_pkg::FUNC_1 && host_irq_en[i] && (i != 3 || !straps.debug_mode)) begin
        pin_out[6+i] = host_irq_src[i];
        pin_oe[6+i]  = 1'b1;
      end
    end
    if (s[8] == pin_mux_pkg::FUNC_2) begin
      pin_out[8] = periph_out.delay_block_out_b;
      pin_oe[8]  = 1'b1;
    end
    // pin 9: debug wire in debug mode, otherwise rapid bit 9 unless host interrupt 3 drives it
    if (straps.debug_mode) begin
      pin_out[9] = periph_out.debug_out;
      pin_oe[9]  = periph_out.debug_oe;
    end else if (!(host_irq_en[3] && s[9] == pin_mux_pkg::FUNC_1)) begin
      pin_out[9] = rio_out[9];
      pin_oe[9]  = rio_dir[9];
    end
  end

  // pull-ups: debug pin always pulled, others per firmware
  always_comb begin
    pin_pull_en    = pull;
    pin_pull_en[9] = 1'b1;
  end

  // peripheral inputs: inactive (idle high or zero) when deselected
  always_comb begin
    periph_in.slave_scl    = (s[0] == pin_mux_pkg::FUNC_1) ? sync2[0] : 1'b1;
    periph_in.slave_sda    = (s[1] == pin_mux_pkg::FUNC_1) ? sync2[1] : 1'b1;
    periph_in.spi_clock    = (s[0] == pin_mux_pkg::FUNC_3) ? sync2[0] : 1'b0;
    periph_in.spi_data_in  = (s[1] == pin_mux_pkg::FUNC_3) ? sync2[1] : 1'b0;
    periph_in.spi_select_n = (s[3] == pin_mux_pkg::FUNC_3) ? sync2[3] : 1'b1;
    periph_in.master_scl   = (s[2] == pin_mux_pkg::FUNC_2) ? sync2[2] : 1'b1;
    periph_in.master_sda   = (s[3] == pin_mux_pkg::FUNC_2) ? sync2[3] : 1'b1;
    periph_in.timer_in[0]  = (s[6] == pin_mux_pkg::FUNC_3) ? sync2[6] : 1'b0;
    periph_in.timer_in[1]  = (s[7] == pin_mux_pkg::FUNC_3) ? sync2[7] : 1'b0;
    periph_in.analog_en[0] = (s[6] == pin_mux_pkg::FUNC_2);
    periph_in.analog_en[1] = (s[7] == pin_mux_pkg::FUNC_2);
    periph_in.debug_in     = straps.debug_mode ? sync2[9] : 1'b1;
  end

  // differential pair needs both pins; conversion is paced by the sensor rate
  assign analog_pair_en = periph_in.analog_en[0] & periph_in.analog_en[1];

  // straps caught once the second sync stage holds the pad level, then frozen;
  // an earlier capture would see the synchronisers' reset value, not the pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_done <= 1'b0;
      strap_age  <= 2'h0;
      straps     <= '0;
    end else if (!strap_done) begin
      if (strap_age == pin_mux_pkg::STRAP_WAIT) begin
        strap_done        <= 1'b1;
        straps.spi_mode   <= ~sync2[3];
        straps.boot_app   <= rst_sync2;
        straps.debug_mode <= ~sync2[9];
      end else begin
        strap_age <= strap_age + 2'h1;
      end
    end
  end

  // interrupt input detection on the synchronised pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_prev <= 1'b0;
    end else begin
      irq_prev <= sync2[4];
    end
  end

  always_comb begin
    case (trig_mode)
      pin_mux_pkg::TRIG_RISE: trig_hit = sync2[4] & ~irq_prev;
      pin_mux_pkg::TRIG_FALL: trig_hit = ~sync2[4] & irq_prev;
      pin_mux_pkg::TRIG_HIGH: trig_hit = sync2[4];
      pin_mux_pkg::TRIG_LOW:  trig_hit = ~sync2[4];
      default:                trig_hit = 1'b0;
    endcase
  end

  // sticky pending; a hit in the clear cycle wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_pending <= 1'b0;
    end else if (trig_hit && s[4] == pin_mux_pkg::FUNC_2) begin
      irq_pending <= 1'b1;
    end else if (irq_clear) begin
      irq_pending <= 1'b0;
    end
  end
  assign irq_level = pin_mux_pkg::WAKE_LEVEL;
  assign wake_req  = irq_pending;

  // reset pin: input only until firmware enables open-drain drive
  assign reset_pin_n_out = 1'b0;
  assign reset_pin_n_oe  = reset_drive_en & reset_drive_assert;
endmodule

`default_nettype wire

// [hdl/pin_mux_pkg.sv]
// shared constants and types for the pin-function mux and boot straps
package pin_mux_pkg;
  localparam int unsigned RIO_WIDTH = 16;
  localparam int unsigned PIN_COUNT = 10;
  localparam int unsigned SEL_WIDTH = 2;
  localparam logic [15:0] RIO_OUT_RESET = 16'h0000;
  localparam logic [15:0] RIO_DIR_RESET = 16'h0000;
  localparam logic [9:0]  PULL_RESET    = 10'h000;
  localparam logic [2:0]  WAKE_LEVEL    = 3'h7;
  // edges after reset release until the second sync stage holds the pads
  localparam logic [1:0]  STRAP_WAIT    = 2'h2;

  // function selection per pin, 0 is the reset function
  localparam logic [1:0] FUNC_1 = 2'h0;
  localparam logic [1:0] FUNC_2 = 2'h1;
  localparam logic [1:0] FUNC_3 = 2'h2;

  // rapid port write operations
  typedef enum logic [3:0] {
    RIO_WRITE  = 4'h1,
    RIO_SET    = 4'h2,
    RIO_CLEAR  = 4'h4,
    RIO_TOGGLE = 4'h8
  } rio_op_t;

  // interrupt input trigger modes
  typedef enum logic [1:0] {
    TRIG_RISE = 2'h0,
    TRIG_FALL = 2'h1,
    TRIG_HIGH = 2'h2,
    TRIG_LOW  = 2'h3
  } trig_mode_t;

  // boot straps captured at reset release
  typedef struct packed {
    logic spi_mode;
    logic boot_app;
    logic debug_mode;
  } strap_t;

  // peripheral outputs toward pins
  typedef struct packed {
    logic master_scl_oe;
    logic master_sda_oe;
    logic spi_data_out;
    logic spi_data_out_oe;
    logic delay_block_out_a;
    logic delay_block_out_b;
    logic [1:0] timer_out;
    logic [1:0] timer_oe;
    logic debug_out;
    logic debug_oe;
  } periph_out_t;

  // pin values delivered to peripherals, inactive when deselected
  typedef struct packed {
    logic slave_scl;
    logic slave_sda;
    logic spi_clock;
    logic spi_data_in;
    logic spi_select_n;
    logic master_scl;
    logic master_sda;
    logic [1:0] timer_in;
    logic [1:0] analog_en;
    logic debug_in;
  } periph_in_t;
endpackage
